// >>> rcsr_pkg.sv
// Shared constants, sizes and CRC helpers for the residual current SPI readout.
package rcsr_pkg;

    // ==========================================================
    // Clock and frame layout
    localparam int CLK_HZ = 200_000_000;
    localparam int WORD_W = 16;
    localparam int PAIR_W = 2 * WORD_W;
    localparam int FRAME_BITS = 40;
    localparam logic [5:0] FRAME_LAST = 6'd39;
    localparam logic [5:0] FRAME_END = 6'd40;

    // ==========================================================
    // Sample coding and the error pattern of the first word
    localparam logic [15:0] ZERO_CODE = 16'h8000;
    localparam logic [15:0] ERR_WORD_BASE = 16'hffc0;
    localparam int ERR_BIT_HW = 3;
    localparam int ERR_BIT_OOR = 1;
    localparam int ERR_BIT_CRIT = 0;
    localparam int THRESHOLD_MA = 160;
    localparam int SENS_CENTI_LSB_PER_MA = 8799;
    localparam logic [15:0] OVERCURRENT_THRESHOLD = 16'(THRESHOLD_MA * SENS_CENTI_LSB_PER_MA / 100);

    // ==========================================================
    // Check byte
    localparam logic [7:0] CRC_SEED = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_GOOD = 8'h00;

    // ==========================================================
    // Timing
    localparam int STARTUP_MS = 100;
    localparam int STARTUP_CYCLES = STARTUP_MS * (CLK_HZ / 1000);
    localparam int FAULT_OUT_HZ = 16_000;
    localparam int FAULT_HALF_CYCLES = CLK_HZ / (2 * FAULT_OUT_HZ);
    localparam int SDM_HZ = 48_000_000;
    localparam logic [8:0] SDM_STEP = 9'(SDM_HZ / 1_000_000);
    localparam logic [8:0] SDM_WRAP = 9'(CLK_HZ / 1_000_000);

    function automatic logic [7:0] crc8_step(input logic [7:0] crc_in, input logic [7:0] data_in);
        logic [7:0] d;
        d = crc_in ^ data_in;
        for (int i = 0; i < 8; i++) begin
            d = d[7] ? ({d[6:0], 1'b0} ^ CRC_POLY) : {d[6:0], 1'b0};
        end
        return d;
    endfunction : crc8_step

    // Most significant byte goes through first.
    function automatic logic [7:0] crc8_words(input logic [31:0] data);
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 3; i >= 0; i--) begin
            c = crc8_step(c, data[i*8 +: 8]);
        end
        return c;
    endfunction : crc8_words

endpackage : rcsr_pkg

// >>> rcsr_link_if.sv
// Internal carrier between the readout core, its sample buffer and its modulator.
`timescale 1ns/1ps
interface rcsr_link_if;
    logic fifo_valid;
    logic fifo_ready;
    logic [rcsr_pkg::PAIR_W-1:0] fifo_data;
    logic sd_en;
    logic [rcsr_pkg::WORD_W-1:0] sd_word;
    logic sd_pos;
    logic sd_neg;

    modport fifo_src (output fifo_valid, output fifo_data, input fifo_ready);
    modport modulator (input sd_en, input sd_word, output sd_pos, output sd_neg);
    modport core (input fifo_valid, input fifo_data, output fifo_ready,
                  output sd_en, output sd_word, input sd_pos, input sd_neg);
endinterface : rcsr_link_if

// >>> rcsr_fifo2.sv
// Small sample buffer between the sensor front end and the frame logic.
`timescale 1ns/1ps
module rcsr_fifo2 #(
    parameter int WIDTH = rcsr_pkg::PAIR_W,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    rcsr_link_if.fifo_src lnk
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
        logic room;
        logic have;
    } rcsr_fifo_t;

    rcsr_fifo_t s;
    rcsr_fifo_t next_s;
    logic push;
    logic pop;

    // ==========================================================
    // Buffer control
    // Ready and valid come from flags kept in step with the count, so both leave on flops.
    assign push = in_valid & s.room;
    assign pop = s.have & lnk.fifo_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr_ptr] = in_data;
            next_s.wr_ptr = (s.wr_ptr == PTR_LAST) ? '0 : s.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_s.rd_ptr = (s.rd_ptr == PTR_LAST) ? '0 : s.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_s.count = s.count + 1'b1;
        end else if (pop && !push) begin
            next_s.count = s.count - 1'b1;
        end
        next_s.room = next_s.count != CNT_FULL;
        next_s.have = next_s.count != '0;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s <= '{room: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign in_ready = s.room;
    assign lnk.fifo_valid = s.have;
    assign lnk.fifo_data = s.mem[s.rd_ptr];

    // ==========================================================
    // Checks
    fifo_bound_a: assert property (@(posedge mclk) disable iff (!resetn)
        s.count <= CNT_FULL && in_ready == (s.count < CNT_FULL))
        else $error("buffer count and ready disagree");
    fifo_full_c: cover property (@(posedge mclk) disable iff (!resetn) !in_ready ##1 in_ready);

endmodule : rcsr_fifo2

// >>> rcsr_sdm.sv
// First-order sigma-delta modulator with a differential bitstream output.
`timescale 1ns/1ps
module rcsr_sdm (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Word in, bitstream out
    rcsr_link_if.modulator lnk
);
    typedef struct packed {
        logic [rcsr_pkg::WORD_W-1:0] acc;
        logic pos;
        logic neg;
    } rcsr_sdm_t;

    rcsr_sdm_t s;
    rcsr_sdm_t next_s;
    logic [rcsr_pkg::WORD_W:0] sum;

    // ==========================================================
    // Modulator
    // The carry of the accumulator is the density-coded bit; mid-scale gives half ones.
    assign sum = {1'b0, s.acc} + {1'b0, lnk.sd_word};

    always_comb begin
        next_s = s;
        if (lnk.sd_en) begin
            next_s.acc = sum[rcsr_pkg::WORD_W-1:0];
            next_s.pos = sum[rcsr_pkg::WORD_W];
            next_s.neg = ~sum[rcsr_pkg::WORD_W];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s <= '{neg: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign lnk.sd_pos = s.pos;
    assign lnk.sd_neg = s.neg;

    // ==========================================================
    // Checks
    sdm_diff_pair_a: assert property (@(posedge mclk) disable iff (!resetn) s.neg == !s.pos)
        else $error("bitstream pair not complementary");
    sdm_step_a: assert property (@(posedge mclk) disable iff (!resetn)
        !lnk.sd_en |=> $stable(s.pos))
        else $error("bitstream moved without enable");

endmodule : rcsr_sdm

// >>> rcsr_readout.sv
// Residual current SPI readout: frame server, fault output, start-up delay and modulator feed.
//
// Summary of operation
// - SPI mode 1; clock idles low, device shifts on rise, master samples on fall.
// - Device is a half-duplex slave only, driving MISO, never starting transfers.
// - A frame is five bytes: fast word, accurate word, check byte.
// - CRC polynomial x^8+x^2+x+1, MSB-first shifts, XOR 0x07 on carry.
// - CRC starts at 0xFF and runs bytes in sending order.
// - Check byte makes the CRC over all five bytes zero.
// - Flag out-of-range when current exceeds the 152 to 175 mA threshold.
// - A hardware fault flag stays set until the next power cycle; here any reset on resetn clears it as well.
// - During any error the first word has bits 15 to 6 set; here it keeps the zero-current code until start-up ends.
// - Error word bit 3 hardware fault, bit 1 out-of-range, bit 0 overload.
// - Error word bit 2 is zero; master ignores bits 5 and 4.
// - The first word, error pattern included, feeds the sigma-delta modulator.
// - Normal operation is reached within 100 ms of power-up or reset.
// - When healthy the fault output toggles at 11 to 21 kHz.
// - A fault shows on the fault output within 200 us.
// - Samples are offset binary, zero current coded as 32768.
// - On any fault the fault output stops toggling and holds steady.
// - Reset is active low and restarts through the start-up delay.
// - Modulator drives a true and inverted pair at 48 MHz.
`timescale 1ns/1ps
module rcsr_readout #(
    parameter int STARTUP_CYCLES = rcsr_pkg::STARTUP_CYCLES,
    parameter int FAULT_HALF_CYCLES = rcsr_pkg::FAULT_HALF_CYCLES,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Sample stream from the measurement front end
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [rcsr_pkg::WORD_W-1:0] sample_fast,
    input wire logic [rcsr_pkg::WORD_W-1:0] sample_accurate,
    // Self-check and overload detection from the front end
    input wire logic hw_fault_evt,
    input wire logic critical_overload,
    // SPI pins
    input wire logic spi_ss_n,
    input wire logic spi_sclk,
    output logic spi_miso,
    // Diagnostic and analog pins
    output logic fault_out,
    output logic analog_pos,
    output logic analog_neg,
    // Status
    output logic ready,
    output logic err_hw,
    output logic err_range,
    output logic err_overload
);
    typedef enum logic {ST_START, ST_RUN} rcsr_phase_t;

    typedef struct packed {
        rcsr_phase_t phase;
        logic [31:0] start_cnt;
        logic [31:0] fault_cnt;
        logic fault_out;
        logic hw_fault;
        logic oor;
        logic crit;
        logic [rcsr_pkg::WORD_W-1:0] fast;
        logic [rcsr_pkg::WORD_W-1:0] accurate;
        logic ss_meta;
        logic ss_sync;
        logic ss_prev;
        logic sclk_meta;
        logic sclk_sync;
        logic sclk_prev;
        logic [rcsr_pkg::FRAME_BITS-1:0] frame;
        logic [5:0] bit_cnt;
        logic miso;
        logic [8:0] sd_phase;
        logic sd_en;
        logic ready;
    } rcsr_state_t;

    localparam rcsr_state_t S_RESET = '{
        phase: ST_START,
        fast: rcsr_pkg::ZERO_CODE,
        accurate: rcsr_pkg::ZERO_CODE,
        ss_meta: 1'b1,
        ss_sync: 1'b1,
        ss_prev: 1'b1,
        default: '0
    };
    localparam logic [31:0] START_LAST = 32'(STARTUP_CYCLES - 1);
    localparam logic [31:0] FAULT_LAST = 32'(FAULT_HALF_CYCLES - 1);

    rcsr_state_t s;
    rcsr_state_t next_s;
    rcsr_link_if lnk ();

    logic any_err;
    logic ss_fall;
    logic sclk_rise;
    logic [rcsr_pkg::WORD_W-1:0] magnitude;
    logic [rcsr_pkg::WORD_W-1:0] word_first;
    logic [rcsr_pkg::WORD_W-1:0] word_second;
    logic [rcsr_pkg::PAIR_W-1:0] pair;
    logic [8:0] sd_sum;

    // ==========================================================
    // Submodules
    rcsr_fifo2 #(
        .WIDTH(rcsr_pkg::PAIR_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data({sample_fast, sample_accurate}),
        .lnk(lnk.fifo_src)
    );

    rcsr_sdm u_sdm (
        .mclk(mclk),
        .resetn(resetn),
        .lnk(lnk.modulator)
    );

    // ==========================================================
    // Frame words
    // Words sit at zero-current code until start-up is over so the host never sees stale data.
    assign any_err = s.hw_fault | s.oor | s.crit;
    assign magnitude = (s.fast >= rcsr_pkg::ZERO_CODE) ? s.fast - rcsr_pkg::ZERO_CODE
                                                       : rcsr_pkg::ZERO_CODE - s.fast;

    always_comb begin
        word_first = rcsr_pkg::ZERO_CODE;
        word_second = rcsr_pkg::ZERO_CODE;
        if (s.phase == ST_RUN) begin
            word_second = s.accurate;
            if (any_err) begin
                word_first = rcsr_pkg::ERR_WORD_BASE;
                word_first[rcsr_pkg::ERR_BIT_HW] = s.hw_fault;
                word_first[rcsr_pkg::ERR_BIT_OOR] = s.oor;
                word_first[rcsr_pkg::ERR_BIT_CRIT] = s.crit;
            end else begin
                word_first = s.fast;
            end
        end
    end

    assign pair = {word_first, word_second};
    assign lnk.sd_word = word_first;
    assign lnk.sd_en = s.sd_en;
    // New samples are only taken while chip select is idle, so the buffer absorbs them meanwhile.
    assign lnk.fifo_ready = s.ss_sync;

    // ==========================================================
    // Link edge detection
    // Only the second and third stage of each pin are looked at.
    assign ss_fall = s.ss_prev & ~s.ss_sync;
    assign sclk_rise = ~s.sclk_prev & s.sclk_sync & ~s.ss_sync;
    // Modulator rate: average of 48 enables per 200 clocks, spread evenly.
    assign sd_sum = s.sd_phase + rcsr_pkg::SDM_STEP;

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.ss_meta = spi_ss_n;
        next_s.ss_sync = s.ss_meta;
        next_s.ss_prev = s.ss_sync;
        next_s.sclk_meta = spi_sclk;
        next_s.sclk_sync = s.sclk_meta;
        next_s.sclk_prev = s.sclk_sync;

        // Start-up delay, restarted by every reset.
        if (s.phase == ST_START) begin
            if (s.start_cnt >= START_LAST) begin
                next_s.phase = ST_RUN;
            end else begin
                next_s.start_cnt = s.start_cnt + 32'h1;
            end
        end
        next_s.ready = s.phase == ST_RUN;

        // Error flags; the hardware fault is only ever set here.
        if (hw_fault_evt) begin
            next_s.hw_fault = 1'b1;
        end
        next_s.crit = critical_overload & (s.phase == ST_RUN);
        next_s.oor = (magnitude > rcsr_pkg::OVERCURRENT_THRESHOLD) & (s.phase == ST_RUN);

        if (lnk.fifo_valid && s.ss_sync) begin
            next_s.fast = lnk.fifo_data[rcsr_pkg::PAIR_W-1:rcsr_pkg::WORD_W];
            next_s.accurate = lnk.fifo_data[rcsr_pkg::WORD_W-1:0];
        end

        // Fault output: square wave while healthy, frozen at once on any error.
        if (s.phase == ST_RUN && !any_err) begin
            if (s.fault_cnt >= FAULT_LAST) begin
                next_s.fault_cnt = '0;
                next_s.fault_out = ~s.fault_out;
            end else begin
                next_s.fault_cnt = s.fault_cnt + 32'h1;
            end
        end else begin
            next_s.fault_cnt = '0;
        end

        // Frame server: latch all five bytes at once, then one bit per rising clock.
        if (ss_fall) begin
            next_s.frame = {pair, rcsr_pkg::crc8_words(pair)};
            next_s.bit_cnt = '0;
            next_s.miso = 1'b0;
        end else if (sclk_rise) begin
            if (s.bit_cnt < rcsr_pkg::FRAME_END) begin
                next_s.miso = s.frame[rcsr_pkg::FRAME_LAST - s.bit_cnt];
                next_s.bit_cnt = s.bit_cnt + 6'h1;
            end else begin
                next_s.miso = 1'b0;
            end
        end
        if (s.ss_sync) begin
            next_s.miso = 1'b0;
        end

        next_s.sd_en = sd_sum >= rcsr_pkg::SDM_WRAP;
        next_s.sd_phase = (sd_sum >= rcsr_pkg::SDM_WRAP) ? sd_sum - rcsr_pkg::SDM_WRAP : sd_sum;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s <= S_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign spi_miso = s.miso;
    assign fault_out = s.fault_out;
    assign analog_pos = lnk.sd_pos;
    assign analog_neg = lnk.sd_neg;
    assign ready = s.ready;
    assign err_hw = s.hw_fault;
    assign err_range = s.oor;
    assign err_overload = s.crit;

    // ==========================================================
    // Helper counters for the checks
    // The age counter saturates and tog_gap clears on each toggle, keeping the checks bounded over long runs.
    logic [31:0] age;
    logic [31:0] tog_gap;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            age <= '0;
            tog_gap <= '0;
        end else begin
            // Ready follows the phase change by one edge, so the age runs one step further.
            if (age <= START_LAST + 32'h1) begin
                age <= age + 32'h1;
            end
            if (!s.ready || any_err || next_s.fault_out != s.fault_out) begin
                tog_gap <= '0;
            end else begin
                tog_gap <= tog_gap + 32'h1;
            end
        end
    end

    // ==========================================================
    // Checks
    frame_len_a: assert property (@(posedge mclk) disable iff (!resetn) s.bit_cnt <= rcsr_pkg::FRAME_END)
        else $error("bit count ran past the frame");
    err_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
        ss_fall && any_err && s.phase == ST_RUN |=> s.frame[39:30] == 10'h3ff)
        else $error("error frame lacks the all-ones field");
    err_bits_a: assert property (@(posedge mclk) disable iff (!resetn)
        ss_fall && any_err && s.phase == ST_RUN
        |=> s.frame[29:24] == {2'b00, $past(s.hw_fault), 1'b0, $past(s.oor), $past(s.crit)})
        else $error("error frame flag bits wrong");
    crc_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
        ss_fall |=> rcsr_pkg::crc8_step(rcsr_pkg::crc8_words(s.frame[39:8]), s.frame[7:0])
            == rcsr_pkg::CRC_GOOD)
        else $error("frame check byte does not zero the CRC");
    frame_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        !s.ss_sync && !ss_fall |=> $stable(s.frame))
        else $error("frame changed during transfer");
    miso_edge_a: assert property (@(posedge mclk) disable iff (!resetn)
        !sclk_rise && !ss_fall && !s.ss_sync |=> $stable(s.miso))
        else $error("MISO moved away from a rising clock");
    hw_sticky_a: assert property (@(posedge mclk) disable iff (!resetn)
        s.hw_fault |=> s.hw_fault [*2])
        else $error("hardware fault flag dropped");
    fault_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        any_err |=> $stable(s.fault_out))
        else $error("fault output toggled during a fault");
    fault_rate_a: assert property (@(posedge mclk) disable iff (!resetn)
        tog_gap < 32'(FAULT_HALF_CYCLES))
        else $error("fault output stopped toggling while healthy");
    start_time_a: assert property (@(posedge mclk) disable iff (!resetn)
        age > START_LAST + 32'h1 |-> s.ready)
        else $error("start-up took too long");
    sd_word_a: assert property (@(posedge mclk) disable iff (!resetn)
        s.phase == ST_RUN && any_err |-> lnk.sd_word[15:6] == 10'h3ff)
        else $error("modulator not fed the error word");

    frame_done_c: cover property (@(posedge mclk) disable iff (!resetn)
        s.bit_cnt == rcsr_pkg::FRAME_END && s.ss_sync);
    err_frame_c: cover property (@(posedge mclk) disable iff (!resetn) ss_fall && any_err);
    fault_freeze_c: cover property (@(posedge mclk) disable iff (!resetn) s.ready && $rose(any_err));
    stall_c: cover property (@(posedge mclk) disable iff (!resetn) !sample_ready && sample_valid);

endmodule : rcsr_readout

// >>> rcsr_spi_host.sv
// SPI mode 1 host model that reads one five-byte frame per call.
`timescale 1ns/1ps
module rcsr_spi_host #(
    // The bench runs the link at a 125 ns period, 25 clocks per bit, leaving the device's sampling a wide margin.
    parameter real HALF = 62.5
) (
    // SPI pins
    output logic ss_n,
    output logic sclk,
    input wire logic miso
);
    initial begin
        ss_n = 1'b1;
        sclk = 1'b0;
    end

    // ==========================================================
    // Frame read
    // The clock stands low outside frames, so the device sees no stray edges.
    task automatic read_frame(output logic [39:0] f);
        ss_n = 1'b0;
        #100;
        for (int i = 39; i >= 0; i--) begin
            sclk = 1'b1;
            #HALF;
            f[i] = miso;
            sclk = 1'b0;
            #HALF;
        end
        #100;
        ss_n = 1'b1;
        #200;
    endtask : read_frame
endmodule : rcsr_spi_host

// >>> tb_top.sv
// Self-checking bench for the residual current SPI readout.
`timescale 1ns/1ps
module tb_top;
    logic mclk, resetn, sample_valid, sample_ready, hw_fault_evt, critical_overload;
    logic [15:0] sample_fast, sample_accurate;
    logic ss_n, sclk, miso, fault_out, analog_pos, analog_neg, ready, err_hw, err_range, err_overload;
    int err_total = 0;
    int checks_done = 0;
    int tog, ones;

    rcsr_readout #(.STARTUP_CYCLES(50), .FAULT_HALF_CYCLES(20), .BUF_DEPTH(2)) i_dut (
        .mclk(mclk), .resetn(resetn), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_fast(sample_fast), .sample_accurate(sample_accurate), .hw_fault_evt(hw_fault_evt),
        .critical_overload(critical_overload), .spi_ss_n(ss_n), .spi_sclk(sclk), .spi_miso(miso),
        .fault_out(fault_out), .analog_pos(analog_pos), .analog_neg(analog_neg), .ready(ready),
        .err_hw(err_hw), .err_range(err_range), .err_overload(err_overload));
    rcsr_spi_host i_host (.ss_n(ss_n), .sclk(sclk), .miso(miso));

    // ==========================================================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Bitwise form of the check byte over the top n bits, so it does not share code with the design.
    function automatic logic [7:0] crc_bits(input logic [39:0] v, input int n);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 39; i >= 40 - n; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc_bits

    function automatic logic [39:0] expf(input logic [15:0] a, input logic [15:0] b);
        return {a, b, crc_bits({a, b, 8'h00}, 32)};
    endfunction : expf

    task automatic push(input logic [15:0] a, input logic [15:0] b);
        sample_fast = a;
        sample_accurate = b;
        sample_valid = 1'b1;
        step(1);
        sample_valid = 1'b0;
        step(4);
    endtask : push

    task automatic rd(input logic [15:0] a, input logic [15:0] b);
        logic [39:0] f;
        i_host.read_frame(f);
        chk(f, expf(a, b));
        chk(crc_bits(f, 40), 40'h0);
        step(6);
        chk(miso, 40'h0);
    endtask : rd

    task automatic watch();
        logic p;
        tog = 0;
        ones = 0;
        p = fault_out;
        repeat (400) begin
            step(1);
            tog += int'(fault_out !== p);
            ones += int'(analog_pos);
            p = fault_out;
            chk(analog_neg ^ analog_pos, 40'h1);
        end
    endtask : watch

    task automatic tally_and_finish();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Clock, watchdog and tests
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        #150000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        resetn = 1'b0;
        sample_valid = 1'b0;
        sample_fast = 16'h8000;
        sample_accurate = 16'h8000;
        hw_fault_evt = 1'b0;
        critical_overload = 1'b0;
        step(8);
        resetn = 1'b1;
        step(49);
        chk(ready, 40'h0);
        step(3);
        chk(ready, 40'h1);
        rd(16'h8000, 16'h8000);
        watch();
        chk(tog >= 19 && tog <= 21, 40'h1);
        chk(ones > 150 && ones < 250, 40'h1);
        $display("test startup done");
        push(16'h8320, 16'he396);
        rd(16'h8320, 16'he396);
        fork
            rd(16'h8320, 16'he396);
            begin
                step(20);
                sample_fast = 16'h7234;
                sample_valid = 1'b1;
                step(3);
                chk(sample_ready, 40'h0);
                sample_fast = 16'h8345;
                sample_accurate = 16'h6789;
                while (sample_ready !== 1'b1) step(1);
                step(1);
                sample_valid = 1'b0;
            end
        join
        step(8);
        rd(16'h8345, 16'h6789);
        $display("test frames done");
        // Exactly 14078 above or below zero is still in range.
        push(16'hb6fe, 16'h1111);
        chk(err_range, 40'h0);
        push(16'h4902, 16'h1111);
        chk(err_range, 40'h0);
        push(16'h4901, 16'h1111);
        chk(err_range, 40'h1);
        push(16'hb6ff, 16'h1111);
        chk(err_range, 40'h1);
        rd(16'hffc2, 16'h1111);
        critical_overload = 1'b1;
        step(3);
        chk(err_overload, 40'h1);
        rd(16'hffc3, 16'h1111);
        watch();
        chk(tog, 40'h0);
        critical_overload = 1'b0;
        push(16'h8000, 16'h2222);
        hw_fault_evt = 1'b1;
        step(1);
        hw_fault_evt = 1'b0;
        step(3);
        chk(err_hw, 40'h1);
        rd(16'hffc8, 16'h2222);
        watch();
        chk(tog, 40'h0);
        chk(err_hw, 40'h1);
        chk(ones > 380, 40'h1);
        $display("test errors done");
        resetn = 1'b0;
        step(2);
        chk({ready, err_hw, fault_out}, 40'h0);
        resetn = 1'b1;
        step(60);
        chk({ready, err_hw}, 40'h2);
        $display("test reset done");
        tally_and_finish();
    end
endmodule : tb_top
